// file: pkg/fwup_cfg.svh
`ifndef FWUP_CFG_SVH
`define FWUP_CFG_SVH

// ==================================================
// Register byte offsets (word aligned)
`define FWUP_OFS_CTRL 6'h00
`define FWUP_OFS_ADDR_LOW 6'h04
`define FWUP_OFS_ADDR_HIGH 6'h08
`define FWUP_OFS_DATA0_LOW 6'h0c
`define FWUP_OFS_DATA0_HIGH 6'h10
`define FWUP_OFS_KEY1_LOW 6'h14
`define FWUP_OFS_KEY1_HIGH 6'h18
`define FWUP_OFS_KEY2_LOW 6'h1c
`define FWUP_OFS_KEY2_HIGH 6'h20
`define FWUP_OFS_KEY3_LOW 6'h24
`define FWUP_OFS_KEY3_HIGH 6'h28
`define FWUP_OFS_STATUS 6'h2c

// ==================================================
// Control register field positions
`define FWUP_BIT_UNLOCKED 7
`define FWUP_BIT_OP_HI 6
`define FWUP_BIT_OP_LO 4
`define FWUP_BIT_ARM 3
`define FWUP_BIT_WSTART 2
`define FWUP_BIT_RDEN 1
`define FWUP_BIT_RSTART 0

// ==================================================
// Reset values
`define FWUP_RST_BYTE 8'h00
`define FWUP_RST_OP 3'h0

// ==================================================
// Operation select codes
`define FWUP_OP_WRITE 3'h0
`define FWUP_OP_ERASE 3'h1
`define FWUP_OP_READ 3'h3
`define FWUP_OP_UNLOCK 3'h6

// ==================================================
// Key pattern, in write order
`define FWUP_KEY1_LOW 8'h00
`define FWUP_KEY1_HIGH 8'h04
`define FWUP_KEY2_LOW 8'h0d
`define FWUP_KEY2_HIGH 8'h09
`define FWUP_KEY3_LOW 8'hc3
`define FWUP_KEY3_HIGH 8'h40

// ==================================================
// Timing
`define FWUP_TMO_US 300
`define FWUP_LOW_SPEED_INTERNAL_OSC_HZ 32000
`define FWUP_TMO_TICKS ((`FWUP_TMO_US * `FWUP_LOW_SPEED_INTERNAL_OSC_HZ) / 1000000)
`define FWUP_CLK_HZ 20000000

`endif

// file: pkg/fwup_pkg.sv
// ==================================================
// Shared types
package fwup_pkg;
    // Flash sequencer states
    typedef enum logic [1:0] {
        FWUP_S_IDLE,
        FWUP_S_ERASE,
        FWUP_S_WRITE,
        FWUP_S_READ
    } fwup_state_t;

    // Flash macro command
    typedef enum logic [1:0] {
        FWUP_CMD_NONE,
        FWUP_CMD_ERASE,
        FWUP_CMD_WRITE,
        FWUP_CMD_READ
    } fwup_cmd_t;

    // Register byte
    typedef logic [7:0] fwup_byte_t;
endpackage

// file: pkg/fwup_tmo_if.sv
`timescale 1ns/10ps
// ==================================================
// Link between the unlock logic and its timeout counter
interface fwup_tmo_if;
    logic start; // Pulse: restart window
    logic run; // Level: window open
    logic expired; // Pulse: window overflowed
    modport ctrl (output start, output run, input expired);
    modport timer (input start, input run, output expired);
endinterface

// file: design/fwup_timeout.sv
`timescale 1ns/10ps
`include "fwup_cfg.svh"
// ==================================================
// Unlock window counter, stepped by low speed oscillator edges
module fwup_timeout #(
    parameter int TICKS = `FWUP_TMO_TICKS
) (
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Low speed oscillator level, synchronous to clk_i
    input wire logic low_speed_internal_osc_i,
    // Control
    fwup_tmo_if.timer tmo
);
    import fwup_pkg::*;

    logic osc_reg; // Previous oscillator level
    logic [15:0] cnt_reg; // Oscillator edges seen
    logic exp_reg; // Expiry pulse
    wire osc_rise = low_speed_internal_osc_i & ~osc_reg;
    wire at_end = (cnt_reg == 16'(TICKS - 1));

    // Count only oscillator edges, never system clocks
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_reg <= 1'b0;
            cnt_reg <= 16'h0000;
            exp_reg <= 1'b0;
        end
        else
        begin
            osc_reg <= low_speed_internal_osc_i;
            exp_reg <= 1'b0;
            if (tmo.start || !tmo.run)
                cnt_reg <= 16'h0000;
            else if (osc_rise)
            begin
                if (at_end)
                    exp_reg <= 1'b1;
                else
                    cnt_reg <= cnt_reg + 16'h0001;
            end
        end
    end

    assign tmo.expired = exp_reg;

    // Expiry only after a full window of edges
    a_tmo_full_window: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(exp_reg) |-> $past(cnt_reg) == 16'(TICKS - 1))
        else $error("timeout fired early");
endmodule

// file: design/fwup_top.sv
`timescale 1ns/10ps
`include "fwup_cfg.svh"
// Contract
// - Unlock window lasts three hundred microseconds (code: nine 32 kHz oscillator edges, at most about 281 us)
// - Window counter steps on low speed oscillator
// - Timeout or bad key disarms, stays locked
// - Correct key unlocks, disarms, sets flag
// - Flash changes only while unlocked flag set
// - Clearing unlocked flag disables writing
// - Page erase covers sixty four words
// - Erase page from high byte, low top bits
// - Page equals high times four plus top bits
// - CPU stalls while write or read start set
// - Key high bytes readable, writable, reset zero
// - Operation codes write, erase, read, unlock
// - Software writes of one to flag ignored
// - Start bits cleared by hardware on completion
// - Data high write loads buffer, bumps address
module fwup_top #(
    parameter int ADDR_HI_W = 6,
    parameter int PAGE_WORDS = 64,
    parameter int TMO_TICKS = `FWUP_TMO_TICKS
) (
    // System
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Oscillator and CPU
    input wire logic low_speed_internal_osc_i,
    output logic cpu_stall_o,
    // Flash macro
    output fwup_pkg::fwup_cmd_t flash_cmd_o,
    output logic [ADDR_HI_W+7:0] flash_addr_o,
    output logic [15:0] flash_wdata_o,
    input wire logic flash_done_i,
    input wire logic [15:0] flash_rdata_i
);
    import fwup_pkg::*;

    localparam int AW = ADDR_HI_W + 8;
    localparam int IW = $clog2(PAGE_WORDS);

    // ==================================================
    // Registers
    logic unlocked_reg; // Write unlocked status flag
    logic [2:0] op_reg; // Operation select
    logic arm_reg; // Unlock armed
    logic wstart_reg; // Write or erase start
    logic rden_reg; // Read enable
    logic rstart_reg; // Read start
    logic [AW-1:0] addr_reg; // Flash address pair
    fwup_byte_t data0_lo_reg; // First data word, low
    fwup_byte_t data0_hi_reg; // First data word, high
    fwup_byte_t key_reg [6]; // Key word bytes 1L..3H
    logic [15:0] wbuf [PAGE_WORDS]; // Page write buffer
    logic ack_reg; // Bus answer
    logic [31:0] rdat_reg; // Bus read data
    fwup_state_t state_reg; // Flash sequencer
    logic [IW-1:0] idx_reg; // Word walk index
    fwup_cmd_t cmd_reg; // Flash command out
    logic [AW-1:0] faddr_reg; // Flash address out
    logic [15:0] fwdata_reg; // Flash data out
    logic stall_reg; // CPU stall out

    // ==================================================
    // Bus decode
    wire acc = wb_cyc_i & wb_stb_i;
    wire wr_fire = acc & wb_we_i & ack_reg & wb_sel_i[0];
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire wr_ctrl = wr_fire && wb_adr_i == `FWUP_OFS_CTRL;
    wire wr_alo = wr_fire && wb_adr_i == `FWUP_OFS_ADDR_LOW;
    wire wr_ahi = wr_fire && wb_adr_i == `FWUP_OFS_ADDR_HIGH;
    wire wr_d0lo = wr_fire && wb_adr_i == `FWUP_OFS_DATA0_LOW;
    wire wr_d0hi = wr_fire && wb_adr_i == `FWUP_OFS_DATA0_HIGH;
    wire [5:0] key_ofs = wb_adr_i - `FWUP_OFS_KEY1_LOW;
    wire key_hit = wb_adr_i >= `FWUP_OFS_KEY1_LOW && wb_adr_i <= `FWUP_OFS_KEY3_HIGH
        && key_ofs[1:0] == 2'h0;
    wire wr_key = wr_fire && key_hit;
    wire [2:0] key_idx = key_ofs[4:2];
    wire wr_last_key = wr_fire && wb_adr_i == `FWUP_OFS_KEY3_HIGH;

    // Control write fields
    wire [2:0] op_new = wbyte[`FWUP_BIT_OP_HI:`FWUP_BIT_OP_LO];
    wire arm_new = wbyte[`FWUP_BIT_ARM];
    wire ws_req = wr_ctrl & wbyte[`FWUP_BIT_WSTART];
    wire rs_req = wr_ctrl & wbyte[`FWUP_BIT_RSTART];
    wire flag_clr = wr_ctrl & ~wbyte[`FWUP_BIT_UNLOCKED];

    // ==================================================
    // Unlock window and key check
    fwup_tmo_if tmo ();
    wire arm_start = wr_ctrl && op_new == `FWUP_OP_UNLOCK && arm_new && !arm_reg;
    wire armed = arm_reg && op_reg == `FWUP_OP_UNLOCK;
    wire key_ok = key_reg[0] == `FWUP_KEY1_LOW && key_reg[1] == `FWUP_KEY1_HIGH
        && key_reg[2] == `FWUP_KEY2_LOW && key_reg[3] == `FWUP_KEY2_HIGH
        && key_reg[4] == `FWUP_KEY3_LOW && wbyte == `FWUP_KEY3_HIGH;
    wire key_done = armed & wr_last_key;
    wire unlock_set = key_done & key_ok & ~tmo.expired;
    wire arm_drop = armed & (tmo.expired | key_done);
    assign tmo.start = arm_start;
    assign tmo.run = armed;

    fwup_timeout #(
        .TICKS(TMO_TICKS)
    ) u_tmo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .low_speed_internal_osc_i(low_speed_internal_osc_i),
        .tmo(tmo)
    );

    // ==================================================
    // Start acceptance and operation decode
    wire op_is_wr = op_reg == `FWUP_OP_WRITE;
    wire op_is_er = op_reg == `FWUP_OP_ERASE;
    wire op_is_rd = op_reg == `FWUP_OP_READ;
    wire idle = state_reg == FWUP_S_IDLE;
    wire [2:0] op_eff = wr_ctrl ? op_new : op_reg;
    wire ws_ok = ws_req && unlocked_reg && !wstart_reg && idle
        && (op_eff == `FWUP_OP_WRITE || op_eff == `FWUP_OP_ERASE);
    wire rs_ok = rs_req && wbyte[`FWUP_BIT_RDEN] && !rstart_reg && idle
        && op_eff == `FWUP_OP_READ;
    wire op_done = !idle && flash_done_i && cmd_reg != FWUP_CMD_NONE;
    wire last_word = idx_reg == IW'(PAGE_WORDS - 1);
    wire seq_end = op_done && (state_reg != FWUP_S_WRITE || last_word);

    // Page number and addresses
    wire [AW-IW-1:0] page = addr_reg[AW-1:IW];
    wire [AW-1:0] word_addr = {page, idx_reg};

    // ==================================================
    // Control register and flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            unlocked_reg <= 1'b0;
            op_reg <= `FWUP_RST_OP;
            arm_reg <= 1'b0;
            wstart_reg <= 1'b0;
            rden_reg <= 1'b0;
            rstart_reg <= 1'b0;
        end
        else
        begin
            // Set wins over a same-cycle clear; writing one does nothing
            if (unlock_set)
                unlocked_reg <= 1'b1;
            else if (flag_clr)
                unlocked_reg <= 1'b0;
            if (wr_ctrl)
            begin
                op_reg <= op_new;
                rden_reg <= wbyte[`FWUP_BIT_RDEN];
            end
            if (arm_drop)
                arm_reg <= 1'b0;
            else if (wr_ctrl)
                arm_reg <= arm_new;
            // Software only sets starts; hardware ends them
            if (ws_ok)
                wstart_reg <= 1'b1;
            else if (seq_end && state_reg != FWUP_S_READ)
                wstart_reg <= 1'b0;
            if (rs_ok)
                rstart_reg <= 1'b1;
            else if (seq_end && state_reg == FWUP_S_READ)
                rstart_reg <= 1'b0;
        end
    end

    // ==================================================
    // Address, data and key registers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            addr_reg <= '0;
            data0_lo_reg <= `FWUP_RST_BYTE;
            data0_hi_reg <= `FWUP_RST_BYTE;
            for (int i = 0; i < 6; i++)
                key_reg[i] <= `FWUP_RST_BYTE;
        end
        else
        begin
            if (wr_alo)
                addr_reg[7:0] <= wbyte;
            else if (wr_ahi)
                addr_reg[AW-1:8] <= wbyte[ADDR_HI_W-1:0];
            else if (wr_d0hi)
                addr_reg <= addr_reg + AW'(1);
            if (wr_d0lo)
                data0_lo_reg <= wbyte;
            else if (op_done && state_reg == FWUP_S_READ)
                data0_lo_reg <= flash_rdata_i[7:0];
            if (wr_d0hi)
                data0_hi_reg <= wbyte;
            else if (op_done && state_reg == FWUP_S_READ)
                data0_hi_reg <= flash_rdata_i[15:8];
            if (wr_key)
                key_reg[key_idx] <= wbyte;
        end
    end

    // Write buffer load on high data byte
    always_ff @(posedge clk_i)
    begin
        if (wr_d0hi)
            wbuf[addr_reg[IW-1:0]] <= {wbyte, data0_lo_reg};
    end

    // ==================================================
    // Flash sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg <= FWUP_S_IDLE;
            idx_reg <= '0;
            cmd_reg <= FWUP_CMD_NONE;
            faddr_reg <= '0;
            fwdata_reg <= 16'h0000;
        end
        else
        begin
            unique case (state_reg)
                FWUP_S_IDLE:
                begin
                    idx_reg <= '0;
                    if (ws_ok && op_eff == `FWUP_OP_ERASE)
                    begin
                        // One command erases the whole page
                        state_reg <= FWUP_S_ERASE;
                        cmd_reg <= FWUP_CMD_ERASE;
                        faddr_reg <= {page, IW'(0)};
                    end
                    else if (ws_ok)
                    begin
                        state_reg <= FWUP_S_WRITE;
                        cmd_reg <= FWUP_CMD_WRITE;
                        faddr_reg <= {page, IW'(0)};
                        fwdata_reg <= wbuf[0];
                    end
                    else if (rs_ok)
                    begin
                        state_reg <= FWUP_S_READ;
                        cmd_reg <= FWUP_CMD_READ;
                        faddr_reg <= addr_reg;
                    end
                end
                FWUP_S_WRITE:
                begin
                    // Walk every buffered word of the page
                    if (op_done && !last_word)
                    begin
                        idx_reg <= idx_reg + IW'(1);
                        faddr_reg <= word_addr + AW'(1);
                        fwdata_reg <= wbuf[idx_reg + IW'(1)];
                    end
                    else if (op_done)
                    begin
                        state_reg <= FWUP_S_IDLE;
                        cmd_reg <= FWUP_CMD_NONE;
                    end
                end
                FWUP_S_ERASE, FWUP_S_READ:
                begin
                    if (op_done)
                    begin
                        state_reg <= FWUP_S_IDLE;
                        cmd_reg <= FWUP_CMD_NONE;
                    end
                end
            endcase
        end
    end

    // ==================================================
    // Bus answer and read data
    wire [7:0] ctrl_rd = {unlocked_reg, op_reg, arm_reg, wstart_reg, rden_reg, rstart_reg};
    wire [7:0] addr_hi_rd = 8'(addr_reg[AW-1:8]);
    wire [7:0] stat_rd = {5'h00, armed, stall_reg, ~idle};
    wire [7:0] rd_byte =
        (wb_adr_i == `FWUP_OFS_CTRL) ? ctrl_rd :
        (wb_adr_i == `FWUP_OFS_ADDR_LOW) ? addr_reg[7:0] :
        (wb_adr_i == `FWUP_OFS_ADDR_HIGH) ? addr_hi_rd :
        (wb_adr_i == `FWUP_OFS_DATA0_LOW) ? data0_lo_reg :
        (wb_adr_i == `FWUP_OFS_DATA0_HIGH) ? data0_hi_reg :
        (key_hit && key_ofs[1:0] == 2'h0) ? key_reg[key_idx] :
        (wb_adr_i == `FWUP_OFS_STATUS) ? stat_rd : 8'h00;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
            stall_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= acc & ~ack_reg;
            if (acc && !ack_reg)
                rdat_reg <= {24'h00_0000, rd_byte};
            // Stall follows the start bits, including a start just granted
            stall_reg <= (wstart_reg | rstart_reg | ws_ok | rs_ok) & ~seq_end;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign cpu_stall_o = stall_reg;
    assign flash_cmd_o = cmd_reg;
    assign flash_addr_o = faddr_reg;
    assign flash_wdata_o = fwdata_reg;

    // ==================================================
    // Checks
    a_unlock_by_key: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(unlocked_reg) |-> $past(key_done) && $past(key_ok))
        else $error("unlock without correct key");
    a_unlock_disarms: assert property (@(posedge clk_i) disable iff (rst_i)
        unlock_set |=> !arm_reg && unlocked_reg)
        else $error("unlock left arm set");
    a_timeout_disarm: assert property (@(posedge clk_i) disable iff (rst_i)
        armed && tmo.expired && !key_done |=> !arm_reg && !$rose(unlocked_reg))
        else $error("timeout did not disarm");
    a_locked_no_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
        (cmd_reg == FWUP_CMD_ERASE || cmd_reg == FWUP_CMD_WRITE)
        && $past(cmd_reg) == FWUP_CMD_NONE |-> $past(unlocked_reg))
        else $error("flash changed while locked");
    a_flag_set_only: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_ctrl && wbyte[`FWUP_BIT_UNLOCKED] && !unlocked_reg && !unlock_set |=> !unlocked_reg)
        else $error("software set the unlocked flag");
    a_stall_on_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (wstart_reg || rstart_reg) && !seq_end |=> stall_reg)
        else $error("cpu not stalled during flash operation");
endmodule

// file: dv/fwup_top_bench.sv
`timescale 1ns/10ps
`include "fwup_cfg.svh"
module fwup_top_bench;
    import fwup_pkg::*;
    // ==================================================
    // Bench signals
    localparam int TMO = 3; // Short unlock window
    localparam logic [5:0] K_OFS [6] = '{`FWUP_OFS_KEY1_LOW, `FWUP_OFS_KEY1_HIGH,
        `FWUP_OFS_KEY2_LOW, `FWUP_OFS_KEY2_HIGH, `FWUP_OFS_KEY3_LOW, `FWUP_OFS_KEY3_HIGH};
    localparam logic [7:0] K_VAL [6] = '{`FWUP_KEY1_LOW, `FWUP_KEY1_HIGH,
        `FWUP_KEY2_LOW, `FWUP_KEY2_HIGH, `FWUP_KEY3_LOW, `FWUP_KEY3_HIGH};
    logic clk_i;
    logic rst_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic cpu_stall_o;
    fwup_cmd_t flash_cmd_o;
    logic [13:0] flash_addr_o;
    logic [15:0] flash_wdata_o;
    logic flash_done_i;
    logic [15:0] flash_rdata_i;
    logic osc_run; // Oscillator enable
    logic [2:0] osc_div; // Oscillator divider
    logic [2:0] resp_cnt; // Flash macro busy time
    int err_total;
    int samples_checked;
    integer seed;
    logic [31:0] q;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] v;
    // ==================================================
    // Device under test
    fwup_top #(.TMO_TICKS(TMO)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .low_speed_internal_osc_i(osc_div[2]), .cpu_stall_o(cpu_stall_o),
        .flash_cmd_o(flash_cmd_o), .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o),
        .flash_done_i(flash_done_i), .flash_rdata_i(flash_rdata_i));
    // System clock, 50 ns
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Slow oscillator, eight clocks a period, stoppable
    always @(posedge clk_i)
    begin
        if (osc_run)
            osc_div <= osc_div + 3'h1;
    end
    // Flash macro: done pulse six clocks into each command
    always @(posedge clk_i)
    begin
        if (flash_cmd_o != FWUP_CMD_NONE && resp_cnt == 3'h5)
        begin
            flash_done_i <= 1'b1;
            flash_rdata_i <= flash_rdata_i * 16'h0fd1 + 16'h03a7;
            resp_cnt <= 3'h0;
        end
        else
        begin
            flash_done_i <= 1'b0;
            resp_cnt <= (flash_cmd_o != FWUP_CMD_NONE) ? resp_cnt + 3'h1 : 3'h0;
        end
    end
    // ==================================================
    // Bus and check tasks
    // One classic cycle, held until ack is sampled
    task automatic xfer(input logic we, input logic [5:0] a, input logic [7:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        r = wb_dat_o;
        if (n >= 50)
            err_total++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [5:0] a, output logic [31:0] r);
        xfer(1'b0, a, 8'h00, r);
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Word address of the erased page
    function automatic logic [13:0] page_addr(input logic [7:0] h, input logic [7:0] l);
        return {h[5:0], l[7:6], 6'h00};
    endfunction
    // Six key bytes, last one spoilt by bad
    task automatic keys(input logic [7:0] bad);
        for (int i = 0; i < 6; i++)
            wr(K_OFS[i], K_VAL[i] ^ ((i == 5) ? bad : 8'h00));
    endtask
    // Start an operation and follow it to the end
    task automatic run_op(input logic [7:0] c, input fwup_cmd_t e, input int b);
        int n;
        n = 0;
        wr(`FWUP_OFS_CTRL, c);
        @(posedge clk_i);
        chk("flash_cmd", 32'(flash_cmd_o), 32'(e));
        chk("stall_on", 32'(cpu_stall_o), 32'h1);
        if (e != FWUP_CMD_READ)
            chk("page_addr", 32'(flash_addr_o), 32'(page_addr(hi, lo)));
        if (e == FWUP_CMD_WRITE)
            chk("write_word", 32'(flash_wdata_o), {16'h0, ~v, v});
        while (flash_cmd_o !== FWUP_CMD_NONE && n < 2000)
        begin
            @(posedge clk_i);
            n++;
        end
        @(posedge clk_i);
        chk("stall_off", 32'(cpu_stall_o), 32'h0);
        rd(`FWUP_OFS_CTRL, q);
        chk("start_bit", 32'(q[b]), 32'h0);
    endtask
    task tally_and_finish;
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ==================================================
    // Scenarios
    initial
    begin
        seed = 32'hfaae27cb;
        err_total = 0;
        samples_checked = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 6'h00;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h00000000;
        osc_run = 1'b0;
        osc_div = 3'h0;
        flash_done_i = 1'b0;
        flash_rdata_i = 16'h5a3c;
        resp_cnt = 3'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // Key bytes reset to zero and hold random values
        for (int i = 0; i < 6; i++)
        begin
            rd(K_OFS[i], q);
            chk("key_reset", q, 32'h0);
            v = 8'($random(seed));
            wr(K_OFS[i], v);
            rd(K_OFS[i], q);
            chk("key_rw", q, {24'h0, v});
        end
        // Write with its byte lane off is ignored
        wb_sel_i <= 4'h0;
        wr(K_OFS[5], ~v);
        wb_sel_i <= 4'h1;
        rd(K_OFS[5], q);
        chk("sel_off", q, {24'h0, v});
        // Unmapped place reads zero
        wr(6'h30, 8'ha5);
        rd(6'h30, q);
        chk("unmapped", q, 32'h0);
        // Locked: erase refused, flag write of one ignored
        wr(`FWUP_OFS_CTRL, 8'h94);
        chk("locked_cmd", 32'(flash_cmd_o), 32'h0);
        rd(`FWUP_OFS_CTRL, q);
        chk("locked_flag", 32'(q[7]), 32'h0);
        chk("locked_start", 32'(q[2]), 32'h0);
        // Wrong key disarms and stays locked
        wr(`FWUP_OFS_CTRL, 8'h68);
        keys(8'h01);
        rd(`FWUP_OFS_CTRL, q);
        chk("bad_key_flag", 32'(q[7]), 32'h0);
        chk("bad_key_arm", 32'(q[3]), 32'h0);
        // Window closes after oscillator edges
        wr(`FWUP_OFS_CTRL, 8'h68);
        osc_run <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(`FWUP_OFS_CTRL, q);
        chk("arm_open", 32'(q[3]), 32'h1);
        repeat ((TMO + 2) * 8) @(posedge clk_i);
        osc_run <= 1'b0;
        rd(`FWUP_OFS_CTRL, q);
        chk("arm_expired", 32'(q[3]), 32'h0);
        keys(8'h00);
        rd(`FWUP_OFS_CTRL, q);
        chk("late_key", 32'(q[7]), 32'h0);
        // Good key after a long pause with the oscillator still
        wr(`FWUP_OFS_CTRL, 8'h68);
        repeat (300) @(posedge clk_i);
        keys(8'h00);
        rd(`FWUP_OFS_CTRL, q);
        chk("unlock_flag", 32'(q[7]), 32'h1);
        chk("unlock_arm", 32'(q[3]), 32'h0);
        // Erase corner and random pages, then write and read
        for (int i = 0; i < 4; i++)
        begin
            hi = (i == 0) ? 8'h3f : (i == 1) ? 8'h00 : 8'($random(seed)) & 8'h3f;
            lo = (i == 0) ? 8'hff : (i == 1) ? 8'h3f : 8'($random(seed));
            wr(`FWUP_OFS_ADDR_HIGH, hi);
            wr(`FWUP_OFS_ADDR_LOW, lo);
            run_op(8'h94, FWUP_CMD_ERASE, 2);
        end
        // Buffer word zero of the page, then program the page
        wr(`FWUP_OFS_ADDR_LOW, lo & 8'hc0);
        wr(`FWUP_OFS_DATA0_LOW, v);
        wr(`FWUP_OFS_DATA0_HIGH, ~v);
        run_op(8'h84, FWUP_CMD_WRITE, 2);
        run_op(8'hb3, FWUP_CMD_READ, 0);
        rd(`FWUP_OFS_DATA0_LOW, q);
        chk("read_low", q, {24'h0, flash_rdata_i[7:0]});
        rd(`FWUP_OFS_DATA0_HIGH, q);
        chk("read_high", q, {24'h0, flash_rdata_i[15:8]});
        // High data byte bumps the address, carry into high byte
        wr(`FWUP_OFS_ADDR_HIGH, 8'h05);
        wr(`FWUP_OFS_ADDR_LOW, 8'hff);
        wr(`FWUP_OFS_DATA0_LOW, v);
        wr(`FWUP_OFS_DATA0_HIGH, v);
        rd(`FWUP_OFS_ADDR_LOW, q);
        chk("addr_low", q, 32'h0);
        rd(`FWUP_OFS_ADDR_HIGH, q);
        chk("addr_high", q, 32'h6);
        // Reserved codes start nothing
        for (int i = 2; i < 8; i++)
        begin
            if (i != 3 && i != 6)
            begin
                wr(`FWUP_OFS_CTRL, {1'b1, 3'(i), 4'h4});
                chk("reserved_cmd", 32'(flash_cmd_o), 32'h0);
            end
        end
        // Clearing the flag locks writing again
        wr(`FWUP_OFS_CTRL, 8'h00);
        rd(`FWUP_OFS_CTRL, q);
        chk("cleared_flag", 32'(q[7]), 32'h0);
        wr(`FWUP_OFS_CTRL, 8'h14);
        chk("relocked_cmd", 32'(flash_cmd_o), 32'h0);
        tally_and_finish();
    end
    // Watchdog against a hung handshake
    initial
    begin
        repeat (40000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end
endmodule
